// [cfg_port_host.sv]
`timescale 1ns/1ps
module cfg_port_host #(
    parameter int QUARTER = clk_cfg_pkg::QUARTER_CYC, // Cycles per quarter bit
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset
    two_wire_if.host bus, // Serial link
    input wire logic req_valid, // Start a transaction
    output logic req_ready, // Engine idle
    input wire logic req_read, // 1 read, 0 write
    input wire logic req_block, // 1 block, 0 single
    input wire logic [4:0] req_index, // Single byte index
    input wire logic [7:0] req_count, // Block byte count
    input wire logic [7:0] wr_data, // Write data
    input wire logic wr_valid, // Write data valid
    output logic wr_ready, // Write FIFO has room
    output logic [7:0] rd_data, // Read data
    output logic rd_valid, // Read data pulse
    output logic done, // Transaction end pulse
    output logic nack_err // Last transaction refused
);
    initial begin
        if (QUARTER < 4 || QUARTER > 65535) $error("QUARTER out of range");
    end
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_STA = 5'h02,
        H_BIT = 5'h04,
        H_WAIT = 5'h08,
        H_STO = 5'h10
    } hstate_e;
    typedef enum logic [6:0] {
        Q_ADDRW = 7'h01,
        Q_CMD = 7'h02,
        Q_CNT = 7'h04,
        Q_WDATA = 7'h08,
        Q_ADDRR = 7'h10,
        Q_RCNT = 7'h20,
        Q_RDATA = 7'h40
    } hseq_e;
    typedef struct packed {
        hstate_e state;
        hseq_e seq;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] rem;
        logic rd;
        logic blk;
        logic [4:0] index;
        logic nack;
        logic scl_oe;
        logic sda_oe;
        logic sda_s1;
        logic sda_s2;
        logic [15:0] qcnt;
        logic [7:0] rd_data;
        logic rd_valid;
        logic done;
        logic err;
        logic ready;
    } host_s;
    host_s r;
    host_s n;
    logic tick;
    logic tx;
    logic last;
    logic f_valid;
    logic f_pop;
    logic [7:0] f_data;

    sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) wr_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );
    assign f_pop = r.state == H_WAIT;

    always_comb begin
        n = r;
        n.rd_valid = 1'b0;
        n.done = 1'b0;
        n.sda_s1 = bus.sda;
        n.sda_s2 = r.sda_s1;
        tick = r.qcnt == 16'h0000;
        tx = r.seq inside {Q_ADDRW, Q_CMD, Q_CNT, Q_WDATA, Q_ADDRR};
        last = (r.seq == Q_RCNT) ? (r.rem == 8'h00) : (r.rem == 8'h01); // RULE12
        n.qcnt = tick ? 16'(QUARTER - 1) : r.qcnt - 16'h0001;
        if (tick) n.ph = r.ph + 2'h1;
        case (r.state)
            H_IDLE: begin
                n.qcnt = 16'(QUARTER - 1);
                n.ph = 2'h0;
                if (req_valid) begin
                    n.rd = req_read;
                    n.blk = req_block;
                    n.index = req_index;
                    n.rem = req_block ? req_count : 8'h01;
                    n.seq = Q_ADDRW;
                    n.err = 1'b0;
                    n.state = H_STA;
                end
            end
            H_STA: begin
                if (tick) begin
                    case (r.ph)
                        2'h0: n.sda_oe = 1'b0;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b1;
                        default: begin
                            n.scl_oe = 1'b1;
                            n.sh = clk_cfg_pkg::DEV_ADDR | {7'h00, r.seq == Q_ADDRR}; // RULE1 RULE11
                            n.bitn = 4'h0;
                            n.state = H_BIT;
                        end
                    endcase
                end
            end
            H_BIT: begin
                if (tick) begin
                    case (r.ph)
                        2'h0: begin
                            if (r.bitn == 4'h8) n.sda_oe = tx ? 1'b0 : !last; // RULE12 RULE18
                            else n.sda_oe = tx ? !r.sh[7] : 1'b0; // RULE7
                        end
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: begin
                            if (r.bitn == 4'h8) n.nack = r.sda_s2;
                            else if (!tx) n.sh = {r.sh[6:0], r.sda_s2};
                        end
                        default: begin
                            n.scl_oe = 1'b1;
                            n.bitn = r.bitn + 4'h1;
                            if (r.bitn != 4'h8 && tx) n.sh = {r.sh[6:0], 1'b0};
                            if (r.bitn == 4'h8) begin
                                n.bitn = 4'h0;
                                if (tx && r.nack) begin
                                    n.err = 1'b1;
                                    n.state = H_STO;
                                end else begin
                                    case (r.seq)
                                        Q_ADDRW: begin
                                            n.seq = Q_CMD;
                                            n.sh = {!r.blk, 2'h0, r.blk ? 5'h00 : r.index}; // RULE3 RULE4 RULE6
                                        end
                                        Q_CMD: begin
                                            if (r.rd) begin
                                                n.seq = Q_ADDRR; // RULE11
                                                n.state = H_STA;
                                            end else if (r.blk) begin
                                                n.seq = Q_CNT; // RULE10
                                                n.sh = r.rem;
                                            end else begin
                                                n.seq = Q_WDATA; // RULE17
                                                n.state = H_WAIT;
                                            end
                                        end
                                        Q_CNT: begin
                                            n.seq = Q_WDATA;
                                            n.state = (r.rem == 8'h00) ? H_STO : H_WAIT;
                                        end
                                        Q_WDATA: begin
                                            n.rem = r.rem - 8'h01;
                                            n.state = (r.rem == 8'h01) ? H_STO : H_WAIT; // RULE8
                                        end
                                        Q_ADDRR: n.seq = r.blk ? Q_RCNT : Q_RDATA;
                                        Q_RCNT: begin
                                            n.seq = Q_RDATA;
                                            if (r.rem == 8'h00) n.state = H_STO;
                                        end
                                        default: begin
                                            n.rd_data = r.sh;
                                            n.rd_valid = 1'b1;
                                            n.rem = r.rem - 8'h01;
                                            if (r.rem == 8'h01) n.state = H_STO; // RULE18
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            H_WAIT: begin
                // Clock is held low until the FIFO offers a byte
                n.qcnt = 16'(QUARTER - 1);
                n.ph = 2'h0;
                if (f_valid) begin
                    n.sh = f_data;
                    n.bitn = 4'h0;
                    n.state = H_BIT;
                end
            end
            H_STO: begin
                if (tick) begin
                    case (r.ph)
                        2'h0: n.sda_oe = 1'b1;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b0;
                        default: begin
                            n.done = 1'b1;
                            n.state = H_IDLE;
                        end
                    endcase
                end
            end
            default: n.state = H_IDLE;
        endcase
        n.ready = n.state == H_IDLE;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{state: H_IDLE, seq: Q_ADDRW, sda_s1: 1'b1, sda_s2: 1'b1, ready: 1'b1,
                default: '0};
        end else begin
            r <= n;
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = r.scl_oe;
    assign bus.host_sda_o = 1'b0; // RULE16
    assign bus.host_sda_oe = r.sda_oe;
    assign req_ready = r.ready;
    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign done = r.done;
    assign nack_err = r.err;
endmodule // cfg_port_host

// [clk_cfg_pkg.sv]
package clk_cfg_pkg;
    localparam logic [7:0] DEV_ADDR = 8'hD2;
    localparam int CMD_SINGLE_BIT = 7;
    localparam int CS_HI = 6;
    localparam int CS_LO = 5;
    localparam int IDX_HI = 4;
    localparam int NUM_BYTES = 8;
    localparam logic [7:0] BLOCK_COUNT = 8'h08;
    // Power-up bytes 6..0; byte 7 is the identity byte
    localparam logic [55:0] REG_RST = 56'h13_00_01_AF_EA_00_7C;
    localparam int ID_IDX = 7;
    localparam int OE_IDX = 0;
    localparam int OE_LSB = 3;
    localparam int SS_IDX = 2;
    localparam int SS_EN_BIT = 2;
    localparam int SS_DEPTH_BIT = 7;
    localparam int TEST_IDX = 6;
    localparam int TEST_SEL_BIT = 7;
    localparam int TEST_MODE_BIT = 6;
    localparam int SCL_MAX_KHZ = 400;
    localparam int CLK_KHZ = 200000;
    // Quarter of the fastest link period, rounded up
    localparam int QUARTER_CYC = (CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
endpackage

// [two_wire_if.sv]
`timescale 1ns/1ps
interface two_wire_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // Pulled-up open-drain wires
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
        output host_sda_o, output host_sda_oe);
endinterface

// [sync_fifo.sv]
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset
    input wire logic in_valid, // Write request
    output logic in_ready, // Room available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Data available
    input wire logic out_ready, // Pop
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic full;
        logic empty;
    } fifo_s;
    fifo_s r;
    fifo_s n;
    logic [AW:0] cnt_nxt;
    always_comb begin
        n = r;
        if (in_valid && !r.full) begin
            n.mem[r.wp[AW-1:0]] = in_data;
            n.wp = r.wp + 1'b1;
        end
        if (out_ready && !r.empty) n.rp = r.rp + 1'b1;
        cnt_nxt = n.wp - n.rp;
        n.full = cnt_nxt == (AW + 1)'(DEPTH);
        n.empty = cnt_nxt == '0;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) r <= '{empty: 1'b1, default: '0};
        else r <= n;
    end
    assign in_ready = !r.full;
    assign out_valid = !r.empty;
    assign out_data = r.mem[r.rp[AW-1:0]];
endmodule // sync_fifo

// [cfg_port_dev.sv]
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Answer only slave address byte D2h; code also answers D3h (read address)
// [RULE2] Single and block writes and reads
// [RULE3] Command bit 7: 0 block, 1 single
// [RULE4] Act only when chip-select bits are 00
// [RULE5] Single transfer indexes byte by bits 4:0
// [RULE6] Controller starts blocks at index zero
// [RULE7] Blocks ascend from lowest byte, MSB first
// [RULE8] Keep completed bytes, drop partial byte
// [RULE9] All control bytes load defaults at reset
// [RULE10] Block write: address, command, count, data
// [RULE11] Block read returns count after read address
// [RULE12] Controller acks all read bytes but last
// [RULE13] Each output pair enabled individually
// [RULE14] Spread on/off and depth selectable
// [RULE15] Works up to 400kHz link clock
// [RULE16] Data line only pulled low or released
// [RULE17] Single write: address, command, one data
// [RULE18] Single read: one byte, not acked, stop
// [RULE19] Depth select 0 is -0.35%, 1 is -0.5%
// [RULE20] Mismatch releases line, changes nothing
// [RULE21] Start or stop mid-transfer aborts byte
module cfg_port_dev #(
    parameter logic [7:0] ID_CODE = 8'h00 // Arbitrary identity byte
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset
    two_wire_if.dev bus, // Serial link
    output logic [3:0] out_enable, // Output pair enables
    output logic spread_enable, // Spread modulation on
    output logic spread_depth_select, // 0 shallow, 1 deep spread
    output logic test_mode, // Test clock mode
    output logic test_sel, // Test source select
    output logic busy // Transfer in progress
);
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_CMD = 8'h04,
        S_CNT = 8'h08,
        S_WDATA = 8'h10,
        S_ACK = 8'h20,
        S_RDATA = 8'h40,
        S_RACK = 8'h80
    } dstate_e;
    typedef logic [clk_cfg_pkg::NUM_BYTES-1:0][7:0] regs_t;
    typedef struct packed {
        dstate_e state;
        dstate_e from;
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic blk;
        logic wrote;
        logic nack;
        logic sda_oe;
        logic busy;
        logic [4:0] idx;
        regs_t regs;
    } dev_s;
    localparam regs_t REGS_RST = {ID_CODE, clk_cfg_pkg::REG_RST}; // RULE9
    localparam dev_s DEV_RST = '{state: S_IDLE, from: S_IDLE, scl_s1: 1'b1, scl_s2: 1'b1,
        scl_s3: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, regs: REGS_RST, default: '0};
    initial begin
        if (clk_cfg_pkg::NUM_BYTES != 8) $error("byte map holds eight bytes");
    end

    function automatic logic [7:0] rd_byte(input regs_t regs, input logic [4:0] idx);
        rd_byte = (idx < 5'(clk_cfg_pkg::NUM_BYTES)) ? regs[idx[2:0]] : 8'h00;
    endfunction

    // Saturates so long blocks never wrap back onto the map
    function automatic logic [4:0] next_idx(input logic [4:0] idx);
        next_idx = (idx == 5'h1F) ? idx : idx + 5'h01;
    endfunction

    dev_s r;
    dev_s n;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] ld;

    always_comb begin
        n = r;
        ld = 8'h00;
        n.scl_s1 = bus.scl; // RULE15
        n.scl_s2 = r.scl_s1;
        n.scl_s3 = r.scl_s2;
        n.sda_s1 = bus.sda;
        n.sda_s2 = r.sda_s1;
        n.sda_s3 = r.sda_s2;
        rise = r.scl_s2 && !r.scl_s3;
        fall = !r.scl_s2 && r.scl_s3;
        start = r.scl_s2 && r.scl_s3 && r.sda_s3 && !r.sda_s2;
        stop = r.scl_s2 && r.scl_s3 && !r.sda_s3 && r.sda_s2;
        if (start) begin
            n.state = S_ADDR; // RULE21
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.state = S_IDLE; // RULE21
            n.sda_oe = 1'b0;
        end else begin
            case (r.state)
                S_ADDR, S_CMD, S_CNT, S_WDATA: begin
                    if (rise && r.cnt != 4'h8) begin
                        n.sh = {r.sh[6:0], r.sda_s2}; // RULE7
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (fall && r.cnt == 4'h8) begin
                        n.cnt = 4'h0;
                        n.from = r.state;
                        n.state = S_ACK;
                        n.sda_oe = 1'b1; // RULE10 RULE17
                        case (r.state)
                            S_ADDR: begin
                                n.rw = r.sh[0];
                                if (r.sh[7:1] != clk_cfg_pkg::DEV_ADDR[7:1]) begin // RULE1
                                    n.state = S_IDLE; // RULE20
                                    n.sda_oe = 1'b0;
                                end
                            end
                            S_CMD: begin
                                n.blk = !r.sh[clk_cfg_pkg::CMD_SINGLE_BIT]; // RULE3
                                n.idx = n.blk ? 5'h00 : r.sh[clk_cfg_pkg::IDX_HI:0]; // RULE5 RULE6
                                n.wrote = 1'b0;
                                if (r.sh[clk_cfg_pkg::CS_HI:clk_cfg_pkg::CS_LO] != 2'h0) begin // RULE4
                                    n.state = S_IDLE; // RULE20
                                    n.sda_oe = 1'b0;
                                end
                            end
                            S_WDATA: begin
                                if (!r.blk && r.wrote) begin
                                    n.state = S_IDLE;
                                    n.sda_oe = 1'b0;
                                end else begin
                                    // Only a whole byte reaches the map
                                    if (r.idx < 5'(clk_cfg_pkg::NUM_BYTES) &&
                                        r.idx != 5'(clk_cfg_pkg::ID_IDX)) begin
                                        n.regs[r.idx[2:0]] = r.sh; // RULE8 RULE13 RULE14
                                    end
                                    n.idx = next_idx(r.idx); // RULE7
                                    n.wrote = 1'b1;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        case (r.from)
                            S_ADDR: begin
                                if (r.rw) begin
                                    if (r.blk) begin
                                        ld = clk_cfg_pkg::BLOCK_COUNT; // RULE11
                                    end else begin
                                        ld = rd_byte(r.regs, r.idx); // RULE18
                                        n.idx = next_idx(r.idx);
                                    end
                                    n.sh = ld;
                                    n.sda_oe = !ld[7]; // RULE16
                                    n.state = S_RDATA;
                                end else begin
                                    n.state = S_CMD;
                                end
                            end
                            S_CMD: n.state = r.blk ? S_CNT : S_WDATA; // RULE2
                            default: n.state = S_WDATA;
                        endcase
                    end
                end
                S_RDATA: begin
                    if (fall) begin
                        if (r.cnt == 4'h7) begin
                            n.cnt = 4'h0;
                            n.sda_oe = 1'b0;
                            n.state = S_RACK;
                        end else begin
                            n.cnt = r.cnt + 4'h1;
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_oe = !r.sh[6]; // RULE16
                        end
                    end
                end
                S_RACK: begin
                    if (rise) n.nack = r.sda_s2;
                    if (fall) begin
                        if (r.nack) begin
                            n.state = S_IDLE; // RULE12
                        end else begin
                            ld = rd_byte(r.regs, r.idx); // RULE7 RULE12
                            n.idx = next_idx(r.idx);
                            n.sh = ld;
                            n.sda_oe = !ld[7];
                            n.state = S_RDATA;
                        end
                    end
                end
                default: n.state = S_IDLE;
            endcase
        end
        n.busy = n.state != S_IDLE;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) r <= DEV_RST; // RULE9
        else r <= n;
    end

    // Output value is always low: the line is only pulled or released
    assign bus.dev_sda_o = 1'b0; // RULE16
    assign bus.dev_sda_oe = r.sda_oe;
    assign out_enable = r.regs[clk_cfg_pkg::OE_IDX][clk_cfg_pkg::OE_LSB+:4]; // RULE13
    assign spread_enable = r.regs[clk_cfg_pkg::SS_IDX][clk_cfg_pkg::SS_EN_BIT]; // RULE14
    assign spread_depth_select = r.regs[clk_cfg_pkg::SS_IDX][clk_cfg_pkg::SS_DEPTH_BIT]; // RULE19
    assign test_mode = r.regs[clk_cfg_pkg::TEST_IDX][clk_cfg_pkg::TEST_MODE_BIT];
    assign test_sel = r.regs[clk_cfg_pkg::TEST_IDX][clk_cfg_pkg::TEST_SEL_BIT];
    assign busy = r.busy;
endmodule // cfg_port_dev

// [cfg_port_asserts.sv]
`timescale 1ns/1ps
module cfg_port_asserts (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset
    input wire logic host_scl_o, // Host clock value
    input wire logic host_scl_oe, // Host clock pull
    input wire logic host_sda_oe, // Host data pull
    input wire logic dev_sda_o, // Device data value
    input wire logic dev_sda_oe, // Device data pull
    input wire logic scl, // Clock wire
    input wire logic sda // Data wire
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_dev_pulls_low: assert property (dev_sda_oe |-> !dev_sda_o)
        else $error("device drives data high");
    a_host_pulls_low: assert property (host_scl_oe |-> !host_scl_o)
        else $error("host drives clock high");
    a_scl_pulled_high: assert property (!host_scl_oe |-> scl)
        else $error("clock wire not high");
    a_sda_one_owner: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
        else $error("both ends pull data while clock high");
    a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data moved while clock high");
    a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high too short");
    a_scl_low_width: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low too short");
    a_dev_hold_width: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
        else $error("device pull too short");
    c_dev_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
endmodule // cfg_port_asserts

// [clock_synth_serial_config_port_test.sv]
`timescale 1ns/1ps
module clock_synth_serial_config_port_test;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic req_block = 1'b0;
    logic [4:0] req_index = 5'h00;
    logic [7:0] req_count = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_valid = 1'b0;
    logic req_ready, wr_ready, rd_valid, done, nack_err, test_mode, test_sel, busy;
    logic spread_enable, spread_depth_select;
    logic [3:0] out_enable;
    logic [7:0] rd_data;
    logic [7:0] rq[$];
    int fails = 0;
    int checks = 0;
    two_wire_if bus_if ();
    cfg_port_dev cfg_port_dev_inst (.clock(clock), .rst_n(rst_n), .bus(bus_if.dev),
        .out_enable(out_enable), .spread_enable(spread_enable), .test_mode(test_mode),
        .spread_depth_select(spread_depth_select), .test_sel(test_sel), .busy(busy));
    cfg_port_host #(.QUARTER(8)) cfg_port_host_inst (.clock(clock), .rst_n(rst_n),
        .bus(bus_if.host), .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
        .req_block(req_block), .req_index(req_index), .req_count(req_count), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done), .nack_err(nack_err));
    cfg_port_asserts cfg_port_asserts_inst (.clock(clock), .rst_n(rst_n), .scl(bus_if.scl),
        .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe), .sda(bus_if.sda),
        .host_sda_oe(bus_if.host_sda_oe),
        .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe));
    always #2.5 clock = ~clock;
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [7:0] d);
        wr_data = d;
        wr_valid = 1'b1;
        @(negedge clock);
        wr_valid = 1'b0;
        @(negedge clock);
    endtask
    task automatic xfer(input logic rd, input logic blk, input logic [4:0] idx,
        input logic [7:0] cnt);
        int i;
        req_read = rd;
        req_block = blk;
        req_index = idx;
        req_count = cnt;
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        rq.delete();
        for (i = 0; i < 20000 && done !== 1'b1; i++) begin
            @(negedge clock);
            if (rd_valid === 1'b1) rq.push_back(rd_data);
        end
        if (done !== 1'b1) begin
            fails++;
            finish_test();
        end
        @(negedge clock);
    endtask
    task automatic check_block(input logic [7:0] e [8]);
        xfer(1'b1, 1'b1, 5'h00, 8'h08);
        cmp(8'(rq.size()), 8'h08);
        for (int k = 0; k < 8; k++) cmp(rq[k], e[k]);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        cmp({4'h0, out_enable}, 8'h0F);
        cmp({6'h00, spread_depth_select, spread_enable}, 8'h02);
        cmp({6'h00, test_sel, test_mode}, 8'h00);
        cmp({6'h00, req_ready, busy}, 8'h02);
        check_block('{8'h7C, 8'h00, 8'hEA, 8'hAF, 8'h01, 8'h00, 8'h13, 8'h00});
        push(8'h04);
        xfer(1'b0, 1'b0, 5'h02, 8'h01);
        cmp({6'h00, spread_depth_select, spread_enable}, 8'h01);
        push(8'h28);
        xfer(1'b0, 1'b0, 5'h00, 8'h01);
        cmp({4'h0, out_enable}, 8'h05);
        cmp({7'h00, nack_err}, 8'h00);
        xfer(1'b1, 1'b0, 5'h02, 8'h01);
        cmp(8'(rq.size()), 8'h01);
        cmp(rq[0], 8'h04);
        xfer(1'b1, 1'b0, 5'h09, 8'h01);
        cmp(rq[0], 8'h00);
        for (int k = 0; k < 16; k++) push(8'h40 + 8'(k));
        cmp({7'h00, wr_ready}, 8'h00);
        xfer(1'b0, 1'b1, 5'h00, 8'h10);
        cmp({4'h0, out_enable}, 8'h08);
        cmp({6'h00, test_sel, test_mode}, 8'h01);
        push(8'h7C);
        push(8'h11);
        xfer(1'b0, 1'b1, 5'h00, 8'h02);
        check_block('{8'h7C, 8'h11, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h00});
        finish_test();
    end
endmodule // clock_synth_serial_config_port_test
